// ---- dbm_buffer_manager.v ----
// Disk buffer manager: sector buffer, command translation, ECC/CRC, retries
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defs.vh"

module dbm_buffer_manager (
	// Clock and reset
	input wire sys_clk,
	input wire reset_n,
	// Host command port
	input wire cmdValid,
	input wire [3:0] cmdCode,
	input wire [7:0] cmdDriveHead,
	input wire [7:0] cmdCount,
	input wire [1:0] cmdSizeSel,
	input wire [3:0] cmdStepRate,
	input wire vectorLoad,
	input wire [7:0] vectorIn,
	// Jumpers
	input wire [2:0] irqLevelJumper,
	input wire [1:0] addrModeJumper,
	// Host or DMA data, into the buffer
	input wire hostInValid,
	input wire [7:0] hostInData,
	output reg hostInReadyReg,
	// Host or DMA data, out of the buffer
	output reg hostOutValidReg,
	output reg [7:0] hostOutDataReg,
	input wire hostOutReady,
	// Disk write stream
	output wire diskOutValid,
	output wire [7:0] diskOutData,
	input wire diskOutReady,
	// Disk read stream, from the drive clock domain
	input wire diskInToggle,
	input wire [7:0] diskInData,
	output reg diskRdReqReg,
	output reg stepPulseReg,
	// Drive and floppy command outputs
	output reg [7:0] floppyCmdReg,
	output reg floppySelReg,
	output reg [1:0] driveSelReg,
	// Interrupts and status
	output reg irqDoneReg,
	output reg irqErrorReg,
	output reg irqDataReqReg,
	output reg [7:0] irqVectorReg,
	output reg [2:0] irqLevelReg,
	output reg [1:0] addrModeReg,
	output reg busyReg,
	output reg correctedReg,
	output reg [3:0] retryCountReg
);
	localparam integer BYTE_CYC = (`DBM_BYTE_NS + `DBM_CLK_NS - 1) / `DBM_CLK_NS;
	localparam integer STEP_CYC = (`DBM_STEP_UNIT_NS + `DBM_CLK_NS - 1) / `DBM_CLK_NS;
	localparam [8:0] S_IDLE = 9'h001;
	localparam [8:0] S_FILL = 9'h002;
	localparam [8:0] S_WAIT = 9'h004;
	localparam [8:0] S_DWR = 9'h008;
	localparam [8:0] S_DCHK = 9'h010;
	localparam [8:0] S_DRD = 9'h020;
	localparam [8:0] S_VERIFY = 9'h040;
	localparam [8:0] S_DRAIN = 9'h080;
	localparam [8:0] S_STEP = 9'h100;

	reg [7:0] mem [0:`DBM_BUF_WORDS-1];
	reg [8:0] stateReg;
	reg [7:0] taskDhReg;
	reg [7:0] taskCountReg;
	reg [3:0] taskCmdReg;
	reg [1:0] taskSizeReg;
	reg [3:0] taskStepReg;
	reg [10:0] ptrReg;
	reg [31:0] eccReg;
	reg [15:0] crcReg;
	reg [31:0] chkRxReg;
	reg [10:0] paceReg;
	reg [10:0] stepTimerReg;
	reg [1:0] syncTogReg;
	reg [7:0] syncData1Reg;
	reg [7:0] syncData2Reg;
	reg togSeenReg;

	wire isDiagRd = (taskCmdReg == `DBM_CMD_DIAG_RD);
	wire isDiagWr = (taskCmdReg == `DBM_CMD_DIAG_WR);
	wire isFormat = (taskCmdReg == `DBM_CMD_FORMAT);
	wire isReadCmd = (taskCmdReg == `DBM_CMD_READ) || isDiagRd;
	wire isFloppy = taskDhReg[`DBM_DH_FLOPPY];
	wire useEcc = !taskDhReg[`DBM_DH_CHECK] && !isFloppy;
	wire [10:0] sectLen = `DBM_SECT_BASE << taskSizeReg;
	wire [10:0] chkLen = useEcc ? `DBM_ECC_BYTES : `DBM_CRC_BYTES;
	wire [10:0] fullLen = sectLen + chkLen;
	wire [31:0] chkVal = useEcc ? eccReg : {16'h0000, crcReg};
	wire [31:0] chkMask = useEcc ? 32'hFFFFFFFF : 32'h0000FFFF;
	wire [31:0] syndrome = (chkVal ^ chkRxReg) & chkMask;
	wire diskByte = syncTogReg[1] ^ togSeenReg;
	wire hostAccept = (stateReg == S_FILL) && hostInValid && hostInReadyReg;
	wire fifoInReady;
	wire sendChk = (stateReg == S_DCHK);
	wire fifoPush = (sendChk || stateReg == S_DWR) && (paceReg == 11'h000);
	wire [10:0] chkIdx = chkLen - ptrReg - 11'h001;
	wire [7:0] chkByte = chkVal[{chkIdx[1:0], 3'b000} +: 8];
	wire [7:0] dwrByte = isFormat ? `DBM_FMT_FILL : mem[ptrReg];
	wire [7:0] fifoData = sendChk ? chkByte : dwrByte;
	wire [1:0] dhDrive = cmdDriveHead[`DBM_DH_DRV_HI:`DBM_DH_DRV_LO];
	wire dhFloppy = cmdDriveHead[`DBM_DH_FLOPPY];
	wire driveOk = dhFloppy || (dhDrive <= `DBM_HARD_MAX);
	wire lastSector = (taskCountReg == 8'h01);
	reg memWe;
	reg [10:0] memAddr;
	reg [7:0] memWd;
	reg [7:0] fcmd;

	function [31:0] eccStep;
		input [31:0] e;
		input [7:0] d;
		integer i;
		reg [31:0] t;
		begin
			t = e;
			for (i = 7; i >= 0; i = i - 1)
				t = {t[30:0], 1'b0} ^ ((t[31] ^ d[i]) ? `DBM_ECC_POLY : 32'h00000000);
			eccStep = t;
		end
	endfunction

	function [15:0] crcStep;
		input [15:0] c;
		input [7:0] d;
		integer i;
		reg [15:0] t;
		begin
			t = c;
			for (i = 7; i >= 0; i = i - 1)
				t = {t[14:0], 1'b0} ^ ((t[15] ^ d[i]) ? `DBM_CRC_POLY : 16'h0000);
			crcStep = t;
		end
	endfunction

	// Hard-disk command format mapped onto the floppy command set
	always @* begin
		case (cmdCode)
			`DBM_CMD_READ, `DBM_CMD_DIAG_RD: fcmd = `DBM_FCMD_READ;
			`DBM_CMD_WRITE, `DBM_CMD_DIAG_WR: fcmd = `DBM_FCMD_WRITE;
			`DBM_CMD_FORMAT: fcmd = `DBM_FCMD_FORMAT;
			`DBM_CMD_SEEK: fcmd = `DBM_FCMD_SEEK;
			default: fcmd = `DBM_FCMD_NONE;
		endcase
	end

	// Buffer write port: host fill, disk capture, burst correction
	always @* begin
		memWe = 1'b0;
		memAddr = ptrReg;
		memWd = hostInData;
		if (hostAccept) begin
			memWe = 1'b1;
		end else if (stateReg == S_DRD && diskByte) begin
			memWe = 1'b1;
			memWd = syncData2Reg;
		end else if (stateReg == S_VERIFY && syndrome != 32'h00000000 &&
				retryCountReg == `DBM_MAX_RETRY && useEcc &&
				(syndrome & `DBM_BURST_MASK) == 32'h00000000) begin
			memWe = 1'b1;
			memAddr = sectLen - 11'h001;
			memWd = mem[sectLen - 11'h001] ^ {3'b000, syndrome[4:0]};
		end
	end

	always @(posedge sys_clk) begin
		if (memWe)
			mem[memAddr] <= memWd;
	end

	// Drive-side byte strobe is a toggle; data is held stable around it
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			syncTogReg <= 2'b00;
			syncData1Reg <= 8'h00;
			syncData2Reg <= 8'h00;
			togSeenReg <= 1'b0;
		end else begin
			syncTogReg <= {syncTogReg[0], diskInToggle};
			syncData1Reg <= diskInData;
			syncData2Reg <= syncData1Reg;
			togSeenReg <= syncTogReg[1];
		end
	end

	dbm_pair_fifo #(
		.WIDTH(8)
	) u_diskFifo (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.inValid(fifoPush),
		.inData(fifoData),
		.inReady(fifoInReady),
		.outValidReg(diskOutValid),
		.outDataReg(diskOutData),
		.outReady(diskOutReady)
	);

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			stateReg <= S_IDLE;
			taskDhReg <= 8'h00;
			taskCountReg <= 8'h00;
			taskCmdReg <= 4'h0;
			taskSizeReg <= 2'h0;
			taskStepReg <= 4'h0;
			ptrReg <= 11'h000;
			eccReg <= `DBM_ECC_INIT;
			crcReg <= `DBM_CRC_INIT;
			chkRxReg <= 32'h00000000;
			paceReg <= 11'h000;
			stepTimerReg <= 11'h000;
			hostInReadyReg <= 1'b0;
			hostOutValidReg <= 1'b0;
			hostOutDataReg <= 8'h00;
			diskRdReqReg <= 1'b0;
			stepPulseReg <= 1'b0;
			floppyCmdReg <= `DBM_FCMD_NONE;
			floppySelReg <= 1'b0;
			driveSelReg <= 2'h0;
			irqDoneReg <= 1'b0;
			irqErrorReg <= 1'b0;
			irqDataReqReg <= 1'b0;
			irqVectorReg <= 8'h00;
			irqLevelReg <= 3'h0;
			addrModeReg <= `DBM_AM_A24;
			busyReg <= 1'b0;
			correctedReg <= 1'b0;
			retryCountReg <= 4'h0;
		end else begin
			diskRdReqReg <= 1'b0;
			stepPulseReg <= 1'b0;
			busyReg <= (stateReg != S_IDLE);
			irqLevelReg <= irqLevelJumper;
			addrModeReg <= (addrModeJumper > `DBM_AM_A16) ? `DBM_AM_A24 : addrModeJumper;
			if (vectorLoad)
				irqVectorReg <= vectorIn;
			if (paceReg != 11'h000)
				paceReg <= paceReg - 11'h001;
			case (stateReg)
				S_IDLE: begin
					if (cmdValid && cmdCode != `DBM_CMD_XFER) begin
						taskCmdReg <= cmdCode;
						taskDhReg <= cmdDriveHead;
						taskCountReg <= cmdCount;
						taskSizeReg <= cmdSizeSel;
						taskStepReg <= cmdStepRate;
						irqDoneReg <= 1'b0;
						irqErrorReg <= 1'b0;
						correctedReg <= 1'b0;
						retryCountReg <= 4'h0;
						ptrReg <= 11'h000;
						eccReg <= `DBM_ECC_INIT;
						crcReg <= `DBM_CRC_INIT;
						driveSelReg <= dhDrive;
						floppySelReg <= dhFloppy;
						floppyCmdReg <= dhFloppy ? fcmd : `DBM_FCMD_NONE;
						if (!driveOk) begin
							irqErrorReg <= 1'b1;
							irqDoneReg <= 1'b1;
						end else begin
							case (cmdCode)
								`DBM_CMD_READ, `DBM_CMD_DIAG_RD: begin
									diskRdReqReg <= 1'b1;
									stateReg <= S_DRD;
								end
								`DBM_CMD_WRITE, `DBM_CMD_DIAG_WR: begin
									hostInReadyReg <= 1'b1;
									irqDataReqReg <= 1'b1;
									stateReg <= S_FILL;
								end
								`DBM_CMD_FORMAT: stateReg <= S_DWR;
								`DBM_CMD_SEEK: begin
									stepTimerReg <= 11'h000;
									stateReg <= S_STEP;
								end
								default: begin
									irqErrorReg <= 1'b1;
									irqDoneReg <= 1'b1;
								end
							endcase
						end
					end
				end
				S_FILL: begin
					if (hostAccept) begin
						ptrReg <= ptrReg + 11'h001;
						eccReg <= eccStep(eccReg, hostInData);
						crcReg <= crcStep(crcReg, hostInData);
						if (ptrReg == (isDiagWr ? fullLen : sectLen) - 11'h001) begin
							hostInReadyReg <= 1'b0;
							irqDataReqReg <= 1'b0;
							stateReg <= S_WAIT;
						end
					end
				end
				S_WAIT: begin
					if (cmdValid && cmdCode == `DBM_CMD_XFER) begin
						ptrReg <= 11'h000;
						stateReg <= isReadCmd ? S_DRAIN : S_DWR;
					end
				end
				S_DWR: begin
					if (fifoPush && fifoInReady) begin
						ptrReg <= ptrReg + 11'h001;
						paceReg <= BYTE_CYC[10:0] - 11'h001;
						if (isFormat) begin
							eccReg <= eccStep(eccReg, `DBM_FMT_FILL);
							crcReg <= crcStep(crcReg, `DBM_FMT_FILL);
						end
						if (ptrReg == (isDiagWr ? fullLen : sectLen) - 11'h001) begin
							ptrReg <= 11'h000;
							if (isDiagWr) begin
								taskCountReg <= taskCountReg - 8'h01;
								stateReg <= lastSector ? S_IDLE : S_FILL;
								hostInReadyReg <= !lastSector;
								irqDataReqReg <= !lastSector;
								irqDoneReg <= lastSector;
							end else begin
								stateReg <= S_DCHK;
							end
						end
					end
				end
				S_DCHK: begin
					if (fifoPush && fifoInReady) begin
						ptrReg <= ptrReg + 11'h001;
						paceReg <= BYTE_CYC[10:0] - 11'h001;
						if (ptrReg == chkLen - 11'h001) begin
							ptrReg <= 11'h000;
							eccReg <= `DBM_ECC_INIT;
							crcReg <= `DBM_CRC_INIT;
							taskCountReg <= taskCountReg - 8'h01;
							irqDoneReg <= lastSector;
							if (lastSector)
								stateReg <= S_IDLE;
							else if (isFormat)
								stateReg <= S_DWR;
							else begin
								hostInReadyReg <= 1'b1;
								irqDataReqReg <= 1'b1;
								stateReg <= S_FILL;
							end
						end
					end
				end
				S_DRD: begin
					if (diskByte) begin
						ptrReg <= ptrReg + 11'h001;
						if (ptrReg < sectLen) begin
							eccReg <= eccStep(eccReg, syncData2Reg);
							crcReg <= crcStep(crcReg, syncData2Reg);
						end else begin
							chkRxReg <= {chkRxReg[23:0], syncData2Reg};
						end
						if (ptrReg == fullLen - 11'h001) begin
							if (isDiagRd) begin
								irqDataReqReg <= 1'b1;
								stateReg <= S_WAIT;
							end else begin
								stateReg <= S_VERIFY;
							end
						end
					end
				end
				S_VERIFY: begin
					ptrReg <= 11'h000;
					eccReg <= `DBM_ECC_INIT;
					crcReg <= `DBM_CRC_INIT;
					chkRxReg <= 32'h00000000;
					if (syndrome != 32'h00000000 && retryCountReg != `DBM_MAX_RETRY) begin
						retryCountReg <= retryCountReg + 4'h1;
						diskRdReqReg <= 1'b1;
						stateReg <= S_DRD;
					end else begin
						if (syndrome != 32'h00000000) begin
							if (useEcc && (syndrome & `DBM_BURST_MASK) == 32'h00000000)
								correctedReg <= 1'b1;
							else
								irqErrorReg <= 1'b1;
						end
						irqDataReqReg <= 1'b1;
						stateReg <= S_WAIT;
					end
				end
				S_DRAIN: begin
					if (!hostOutValidReg || hostOutReady) begin
						if (ptrReg != (isDiagRd ? fullLen : sectLen)) begin
							hostOutValidReg <= 1'b1;
							hostOutDataReg <= mem[ptrReg];
							ptrReg <= ptrReg + 11'h001;
						end else begin
							hostOutValidReg <= 1'b0;
							irqDataReqReg <= 1'b0;
							ptrReg <= 11'h000;
							taskCountReg <= taskCountReg - 8'h01;
							irqDoneReg <= lastSector;
							diskRdReqReg <= !lastSector;
							stateReg <= lastSector ? S_IDLE : S_DRD;
						end
					end
				end
				S_STEP: begin
					if (stepTimerReg != 11'h000) begin
						stepTimerReg <= stepTimerReg - 11'h001;
					end else if (taskCountReg == 8'h00) begin
						irqDoneReg <= 1'b1;
						stateReg <= S_IDLE;
					end else begin
						stepPulseReg <= 1'b1;
						taskCountReg <= taskCountReg - 8'h01;
						stepTimerReg <= ({7'h00, taskStepReg} + 11'h001) * STEP_CYC[10:0] - 11'h001;
					end
				end
				default: stateReg <= S_IDLE;
			endcase
		end
	end
endmodule // dbm_buffer_manager

`default_nettype wire

// ---- dbm_buffer_manager_chk.sv ----
// Port checker for the disk buffer manager
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defs.vh"
module dbm_buffer_manager_chk (
	// Clock and reset
	input wire sys_clk,
	input wire reset_n,
	// Watched inputs
	input wire cmdValid,
	input wire [3:0] cmdCode,
	input wire [7:0] cmdDriveHead,
	input wire vectorLoad,
	input wire [7:0] vectorIn,
	input wire [2:0] irqLevelJumper,
	input wire [1:0] addrModeJumper,
	input wire diskOutReady,
	// Watched outputs
	input wire hostInReadyReg,
	input wire diskOutValid,
	input wire [7:0] diskOutData,
	input wire diskRdReqReg,
	input wire stepPulseReg,
	input wire irqDoneReg,
	input wire irqErrorReg,
	input wire irqDataReqReg,
	input wire [7:0] irqVectorReg,
	input wire [2:0] irqLevelReg,
	input wire [1:0] addrModeReg,
	input wire busyReg
);
	wire badHard = !cmdDriveHead[5] && cmdDriveHead[4:3] == 2'h3;
	wire takeCmd = cmdValid && !busyReg;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	write_opens_a: assert property (takeCmd && cmdCode == `DBM_CMD_WRITE && !badHard
		|=> hostInReadyReg && irqDataReqReg ##1 busyReg) else $error("write did not open");
	read_request_a: assert property (takeCmd && cmdCode == `DBM_CMD_READ && !badHard
		|=> diskRdReqReg) else $error("read request missing");
	bad_drive_a: assert property (takeCmd && cmdCode == `DBM_CMD_WRITE && badHard
		|=> irqErrorReg && irqDoneReg) else $error("bad drive not refused");
	vector_load_a: assert property (vectorLoad
		|=> irqVectorReg == $past(vectorIn)) else $error("vector not loaded");
	irq_level_a: assert property ($past(reset_n)
		|-> irqLevelReg == $past(irqLevelJumper)) else $error("level not followed");
	addr_mode_a: assert property ($past(reset_n) |-> addrModeReg ==
		(($past(addrModeJumper) == 2'h3) ? `DBM_AM_A24 : $past(addrModeJumper)))
		else $error("address mode wrong");
	step_pulse_a: assert property (stepPulseReg
		|=> !stepPulseReg [*8]) else $error("step pulses too close");
	disk_hold_a: assert property (diskOutValid && !diskOutReady
		|=> diskOutValid && $stable(diskOutData)) else $error("disk byte dropped");
	// A check byte from the previous sector may still drain while the next fill opens
	xfer_gate_a: assert property (hostInReadyReg && !diskOutValid
		|=> !diskOutValid) else $error("disk write before transfer");
endmodule // dbm_buffer_manager_chk
`default_nettype wire

// ---- dbm_buffer_manager_test.sv ----
// Self-checking bench for the disk buffer manager
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defs.vh"
module dbm_buffer_manager_test;
	logic sys_clk, reset_n, cmdValid, vectorLoad, diskOutReady, runEn, slowMode;
	logic diskInToggle;
	logic [7:0] diskInData;
	logic [1:0] cmdSizeSel;
	wire hostOutValidReg, diskRdReqReg, correctedReg;
	wire [7:0] hostOutDataReg;
	wire [3:0] retryCountReg;
	logic [3:0] cmdCode, cmdStepRate;
	logic [7:0] cmdDriveHead, cmdCount, vectorIn;
	logic [2:0] irqLevelJumper;
	logic [1:0] addrModeJumper;
	wire hostInValid, hostInReadyReg, diskOutValid, stepPulseReg, floppySelReg;
	wire irqDoneReg, irqErrorReg, irqDataReqReg, busyReg;
	wire [7:0] hostInData, diskOutData, floppyCmdReg, irqVectorReg;
	wire [1:0] driveSelReg, addrModeReg;
	wire [2:0] irqLevelReg;
	int cyc = 0;
	int failCount = 0;
	int testsRun = 0;
	dbm_buffer_manager dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .cmdValid(cmdValid),
		.cmdCode(cmdCode), .cmdDriveHead(cmdDriveHead), .cmdCount(cmdCount),
		.cmdSizeSel(cmdSizeSel), .cmdStepRate(cmdStepRate), .vectorLoad(vectorLoad),
		.vectorIn(vectorIn), .irqLevelJumper(irqLevelJumper), .addrModeJumper(addrModeJumper),
		.hostInValid(hostInValid), .hostInData(hostInData), .hostInReadyReg(hostInReadyReg),
		.hostOutValidReg(hostOutValidReg), .hostOutDataReg(hostOutDataReg), .hostOutReady(1'b1),
		.diskOutValid(diskOutValid), .diskOutData(diskOutData), .diskOutReady(diskOutReady),
		.diskInToggle(diskInToggle), .diskInData(diskInData), .diskRdReqReg(diskRdReqReg),
		.stepPulseReg(stepPulseReg),
		.floppyCmdReg(floppyCmdReg), .floppySelReg(floppySelReg), .driveSelReg(driveSelReg),
		.irqDoneReg(irqDoneReg), .irqErrorReg(irqErrorReg), .irqDataReqReg(irqDataReqReg),
		.irqVectorReg(irqVectorReg), .irqLevelReg(irqLevelReg), .addrModeReg(addrModeReg),
		.busyReg(busyReg), .correctedReg(correctedReg), .retryCountReg(retryCountReg));
	dbm_dma_model dma_u (.sys_clk(sys_clk), .runEn(runEn), .slowMode(slowMode),
		.byteCount(11'h080), .hostInValid(hostInValid), .hostInData(hostInData),
		.hostInReady(hostInReadyReg));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			failCount++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic issue(input logic [3:0] code, input logic [7:0] dh, input logic [7:0] cnt);
		@(negedge sys_clk);
		cmdCode = code;
		cmdDriveHead = dh;
		cmdCount = cnt;
		cmdValid = 1'b1;
		@(negedge sys_clk);
		cmdValid = 1'b0;
	endtask
	task automatic do_reset;
		@(negedge sys_clk);
		reset_n = 1'b0;
		repeat (3) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic wait_idle;
		repeat (50) if (busyReg) @(negedge sys_clk);
	endtask
	function automatic logic [31:0] upd(input logic [31:0] c, input logic [7:0] d, input bit ecc);
		for (int j = 7; j >= 0; j--)
			if (ecc)
				c = {c[30:0], 1'b0} ^ ((c[31] ^ d[j]) ? `DBM_ECC_POLY : 32'h0);
			else
				c[15:0] = {c[14:0], 1'b0} ^ ((c[15] ^ d[j]) ? `DBM_CRC_POLY : 16'h0);
		return c;
	endfunction
	task automatic test_regs;
		@(negedge sys_clk);
		vectorIn = 8'hC3;
		vectorLoad = 1'b1;
		@(negedge sys_clk);
		vectorLoad = 1'b0;
		check("vector", irqVectorReg, 8'hC3);
		irqLevelJumper = 3'h6;
		addrModeJumper = 2'h3;
		repeat (2) @(negedge sys_clk);
		check("irq level", irqLevelReg, 3'h6);
		check("addr mode", addrModeReg, `DBM_AM_A24);
		addrModeJumper = `DBM_AM_A16;
		repeat (2) @(negedge sys_clk);
		check("addr mode", addrModeReg, `DBM_AM_A16);
		$display("register test done");
	endtask
	task automatic test_bad_drive;
		issue(`DBM_CMD_WRITE, 8'h18, 8'h01);
		@(posedge sys_clk);
		#1;
		check("error irq", irqErrorReg, 1'b1);
		check("done irq", irqDoneReg, 1'b1);
		wait_idle;
		$display("bad drive test done");
	endtask
	task automatic test_seek;
		int t0;
		cmdStepRate = 4'h1;
		issue(`DBM_CMD_SEEK, 8'h00, 8'h02);
		repeat (400) if (!stepPulseReg) @(negedge sys_clk);
		t0 = cyc;
		@(negedge sys_clk);
		repeat (400) if (!stepPulseReg) @(negedge sys_clk);
		check("step spacing", cyc - t0, 200);
		repeat (400) if (!irqDoneReg) @(negedge sys_clk);
		check("seek done", irqDoneReg, 1'b1);
		wait_idle;
		$display("seek test done");
	endtask
	task automatic test_write(input logic [7:0] dh, input bit ecc, input logic slow);
		logic [31:0] chk;
		logic [7:0] b;
		int n;
		chk = ecc ? `DBM_ECC_INIT : {16'h0, `DBM_CRC_INIT};
		n = ecc ? 4 : 2;
		issue(`DBM_CMD_WRITE, dh, 8'h01);
		@(posedge sys_clk);
		#1;
		check("data request up", irqDataReqReg, 1'b1);
		check("in ready up", hostInReadyReg, 1'b1);
		@(negedge sys_clk);
		slowMode <= slow;
		runEn <= 1'b1;
		repeat (1000) if (irqDataReqReg) @(negedge sys_clk);
		check("data request down", irqDataReqReg, 1'b0);
		check("in ready down", hostInReadyReg, 1'b0);
		runEn <= 1'b0;
		repeat (20) @(negedge sys_clk);
		check("early disk byte", diskOutValid, 1'b0);
		issue(`DBM_CMD_XFER, dh, 8'h01);
		// Stall the drive so both buffer entries fill
		repeat (600) @(negedge sys_clk);
		diskOutReady = 1'b1;
		for (int i = 0; i < 128 + n; i++) begin
			repeat (400) if (!diskOutValid) @(negedge sys_clk);
			b = (i < 128) ? (i[7:0] ^ 8'h5A) : chk[(8 * (n - 1 - (i - 128)))+:8];
			check("disk byte", diskOutData, b);
			if (i < 128)
				chk = upd(chk, b, ecc);
			@(negedge sys_clk);
		end
		repeat (20) if (!irqDoneReg) @(negedge sys_clk);
		check("write done", irqDoneReg, 1'b1);
		check("extra check byte", diskOutValid, 1'b0);
		diskOutReady = 1'b0;
		wait_idle;
		$display("write test done");
	endtask
	// Drive sends sectors with ECC; a nonzero flip spoils the last check byte every time
	task automatic test_read(input logic [1:0] sel, input logic [7:0] flip);
		logic [31:0] chk;
		logic [7:0] b;
		int len;
		len = `DBM_SECT_BASE << sel;
		cmdSizeSel = sel;
		issue(`DBM_CMD_READ, 8'h00, 8'h01);
		repeat ((flip != 8'h00) ? `DBM_MAX_RETRY + 1 : 1) begin
			repeat (50) if (!diskRdReqReg) @(negedge sys_clk);
			chk = `DBM_ECC_INIT;
			for (int i = 0; i < len + 4; i++) begin
				b = (i < len) ? (i[7:0] ^ 8'hA5) : chk[8 * (len + 3 - i)+:8];
				if (i < len)
					chk = upd(chk, b, 1'b1);
				if (i == len + 3)
					b = b ^ flip;
				diskInData = b;
				repeat (4) @(negedge sys_clk);
				diskInToggle = !diskInToggle;
				repeat (4) @(negedge sys_clk);
			end
		end
		repeat (20) if (!irqDataReqReg) @(negedge sys_clk);
		check("read data request", irqDataReqReg, 1'b1);
		check("read error", irqErrorReg, 1'b0);
		check("retries", retryCountReg, (flip != 8'h00) ? `DBM_MAX_RETRY : 4'h0);
		check("corrected", correctedReg, flip != 8'h00);
		issue(`DBM_CMD_XFER, 8'h00, 8'h01);
		repeat (20) if (!hostOutValidReg) @(negedge sys_clk);
		for (int i = 0; i < len; i++) begin
			b = i[7:0] ^ 8'hA5;
			check("host byte", hostOutDataReg, (i == len - 1) ? b ^ flip : b);
			@(negedge sys_clk);
		end
		check("read done", irqDoneReg, 1'b1);
		check("read drained", hostOutValidReg, 1'b0);
		$display("read test done");
	endtask
	task automatic test_floppy;
		logic [3:0] codes [4];
		logic [7:0] fcmd [4];
		codes = '{`DBM_CMD_READ, `DBM_CMD_WRITE, `DBM_CMD_FORMAT, `DBM_CMD_SEEK};
		fcmd = '{`DBM_FCMD_READ, `DBM_FCMD_WRITE, `DBM_FCMD_FORMAT, `DBM_FCMD_SEEK};
		for (int k = 0; k < 4; k++) begin
			issue(codes[k], {3'b001, k[1:0], 3'b000}, 8'h00);
			repeat (2) @(negedge sys_clk);
			check("floppy command", floppyCmdReg, fcmd[k]);
			check("floppy select", floppySelReg, 1'b1);
			check("drive select", driveSelReg, k[1:0]);
			do_reset;
		end
		$display("floppy test done");
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;
	initial begin
		#800000;
		failCount++;
		report_and_stop;
	end
	initial begin
		reset_n = 1'b0;
		{cmdValid, vectorLoad, diskOutReady, runEn, slowMode} = 5'h00;
		{cmdCode, cmdStepRate, cmdDriveHead, cmdCount, vectorIn} = 32'h0;
		{diskInToggle, diskInData, cmdSizeSel} = 11'h000;
		irqLevelJumper = 3'h2;
		addrModeJumper = `DBM_AM_A32;
		repeat (3) @(negedge sys_clk);
		check("reset mode", addrModeReg, `DBM_AM_A24);
		check("reset done", irqDoneReg, 1'b0);
		reset_n = 1'b1;
		repeat (2) @(negedge sys_clk);
		test_regs;
		test_bad_drive;
		test_seek;
		test_write(8'h00, 1'b1, 1'b0);
		test_write(8'h88, 1'b0, 1'b1);
		test_read(2'h1, 8'h00);
		test_read(2'h0, 8'h01);
		test_floppy;
		report_and_stop;
	end
endmodule // dbm_buffer_manager_test
bind dbm_buffer_manager dbm_buffer_manager_chk chk_u (.sys_clk(sys_clk), .reset_n(reset_n),
	.cmdValid(cmdValid), .cmdCode(cmdCode), .cmdDriveHead(cmdDriveHead),
	.vectorLoad(vectorLoad), .vectorIn(vectorIn), .irqLevelJumper(irqLevelJumper),
	.addrModeJumper(addrModeJumper), .diskOutReady(diskOutReady),
	.hostInReadyReg(hostInReadyReg), .diskOutValid(diskOutValid), .diskOutData(diskOutData),
	.diskRdReqReg(diskRdReqReg), .stepPulseReg(stepPulseReg), .irqDoneReg(irqDoneReg),
	.irqErrorReg(irqErrorReg), .irqDataReqReg(irqDataReqReg), .irqVectorReg(irqVectorReg),
	.irqLevelReg(irqLevelReg), .addrModeReg(addrModeReg), .busyReg(busyReg));
`default_nettype wire

// ---- dbm_defs.vh ----
// Constants shared by the disk buffer manager files
`ifndef DBM_DEFS_VH
`define DBM_DEFS_VH

// Sector buffer
`define DBM_BUF_AW 11
`define DBM_BUF_WORDS 2048
`define DBM_SECT_BASE 11'h080

// Drive/head select layout
`define DBM_DH_CHECK 7
`define DBM_DH_FLOPPY 5
`define DBM_DH_DRV_HI 4
`define DBM_DH_DRV_LO 3
`define DBM_HARD_MAX 2'h2

// Host command codes
`define DBM_CMD_READ 4'h1
`define DBM_CMD_WRITE 4'h2
`define DBM_CMD_FORMAT 4'h3
`define DBM_CMD_SEEK 4'h4
`define DBM_CMD_XFER 4'h5
`define DBM_CMD_DIAG_RD 4'h6
`define DBM_CMD_DIAG_WR 4'h7

// Floppy command format
`define DBM_FCMD_NONE 8'h00
`define DBM_FCMD_SEEK 8'h10
`define DBM_FCMD_READ 8'h80
`define DBM_FCMD_WRITE 8'hA0
`define DBM_FCMD_FORMAT 8'hF0

// Check codes
`define DBM_ECC_BYTES 11'h004
`define DBM_CRC_BYTES 11'h002
`define DBM_ECC_POLY 32'h04C11DB7
`define DBM_ECC_INIT 32'h00000000
`define DBM_CRC_POLY 16'h1021
`define DBM_CRC_INIT 16'hFFFF
`define DBM_BURST_MASK 32'hFFFFFFE0
`define DBM_MAX_RETRY 4'h8
`define DBM_FMT_FILL 8'hE5

// Timing
`define DBM_CLK_NS 10
`define DBM_BYTE_NS 1600
`define DBM_STEP_UNIT_NS 1000

// Bus addressing jumpers
`define DBM_AM_A32 2'h0
`define DBM_AM_A24 2'h1
`define DBM_AM_A16 2'h2

`endif

// ---- dbm_dma_model.sv ----
// Host-side DMA source that fills the sector buffer
`timescale 1ns/1ps
`default_nettype none
module dbm_dma_model (
	// Clock
	input wire sys_clk,
	// Control from the bench
	input wire runEn,
	input wire slowMode,
	input wire [10:0] byteCount,
	// Buffer fill port
	output logic hostInValid,
	output logic [7:0] hostInData,
	input wire hostInReady
);
	logic [10:0] sentReg;
	logic tookReg;
	initial begin
		hostInValid = 1'b0;
		hostInData = 8'h00;
	end
	always @(posedge sys_clk) begin
		tookReg <= hostInValid && hostInReady;
		if (!runEn)
			sentReg <= 11'h000;
		else if (hostInValid && hostInReady)
			sentReg <= sentReg + 11'h001;
	end
	// Held until taken; a slow host idles a cycle after each byte
	always @(negedge sys_clk) begin
		if (runEn && sentReg < byteCount && !(slowMode && tookReg)) begin
			hostInValid <= 1'b1;
			hostInData <= sentReg[7:0] ^ 8'h5A;
		end else begin
			hostInValid <= 1'b0;
			// Released data keeps moving so a stale byte is never mistaken for real
			hostInData <= ~hostInData;
		end
	end
endmodule // dbm_dma_model
`default_nettype wire

// ---- dbm_pair_fifo.v ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module dbm_pair_fifo #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset_n,
	// Filling side
	input wire inValid,
	input wire [WIDTH-1:0] inData,
	output wire inReady,
	// Draining side
	output reg outValidReg,
	output reg [WIDTH-1:0] outDataReg,
	input wire outReady
);
	reg [WIDTH-1:0] slot1Reg;
	reg v1Reg;
	wire pop;
	wire push;

	assign inReady = !v1Reg;
	assign pop = outValidReg && outReady;
	assign push = inValid && !v1Reg;

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			outValidReg <= 1'b0;
			outDataReg <= {WIDTH{1'b0}};
			slot1Reg <= {WIDTH{1'b0}};
			v1Reg <= 1'b0;
		end else if (pop) begin
			if (v1Reg) begin
				outDataReg <= slot1Reg;
				if (push)
					slot1Reg <= inData;
				else
					v1Reg <= 1'b0;
			end else if (push) begin
				outDataReg <= inData;
			end else begin
				outValidReg <= 1'b0;
			end
		end else if (push) begin
			if (!outValidReg) begin
				outDataReg <= inData;
				outValidReg <= 1'b1;
			end else begin
				slot1Reg <= inData;
				v1Reg <= 1'b1;
			end
		end
	end
endmodule // dbm_pair_fifo

`default_nettype wire
